// ==== hdl/fdc_device.sv ====
// module: controller input status, rate config, reset sequencing and density select
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fdc_device (
  input wire logic i_mclk,
  input wire logic i_reset,
  fdc_if.device bus,
  input wire fdc_pkg::fdc_mode_t i_mode,
  input wire logic i_disk_change_n,
  input wire logic i_ident_strap,
  input wire logic i_invert_n,
  input wire logic i_fifo_lock,
  input wire logic i_read_data,
  input wire logic i_data_window,
  input wire logic i_xfer_active,
  output logic o_density_select_out,
  output logic o_core_reset,
  output logic o_fifo_reset,
  output logic o_power_down,
  output logic o_polling,
  output logic [7:0] o_clock_byte,
  output logic [7:0] o_data_byte,
  output logic o_byte_valid,
  output logic [7:0] o_fifo_wdata,
  output logic o_fifo_write,
  output logic o_fifo_read
);
  logic disk_change_flag_s, ident_s, invert_n_s, rdata_s, window_s;
  fdc_sync u_sync_disk_change_flag (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(i_disk_change_n), .o_level(disk_change_flag_s));
  fdc_sync u_sync_ident (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(i_ident_strap), .o_level(ident_s));
  fdc_sync u_sync_invert (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(i_invert_n), .o_level(invert_n_s));
  fdc_sync u_sync_rdata (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(i_read_data), .o_level(rdata_s));
  fdc_sync u_sync_window (.i_mclk(i_mclk), .i_reset(i_reset), .i_pin(i_data_window), .o_level(window_s));

  logic [1:0] rate_ff;
  logic [2:0] precompensation_setting_ff;
  logic precompensation_setting_dis_ff;
  logic [7:0] dor_ff;
  logic sw_reset_ff;
  logic power_down_ff;
  logic ident_ff;
  logic ident_take_ff;
  logic density_ff;
  logic [7:0] rdata_ff;
  logic [7:0] oe_n_ff;
  logic dma_req_ff;
  logic core_reset_ff, fifo_reset_ff, polling_ff, in_reset_ff;
  logic [7:0] clk_sr_ff, dat_sr_ff, clk_byte_ff, dat_byte_ff;
  logic [2:0] bit_cnt_ff;
  logic byte_valid_ff, window_d_ff;
  logic [7:0] fifo_wdata_ff;
  logic fifo_write_ff, fifo_read_ff;

  // register strobes; dma acknowledge reaches the fifo without chip select
  wire cs_wr = bus.cs & bus.wr;
  wire cs_rd = bus.cs & bus.rd;
  wire wr_ccr = cs_wr & (bus.sel == fdc_pkg::SEL_CONFIG_CONTROL);
  wire wr_dor = cs_wr & (bus.sel == fdc_pkg::SEL_DIGITAL_OUTPUT);
  wire wr_rsr = cs_wr & (bus.sel == fdc_pkg::SEL_RATE_SELECT);
  wire rd_dir = cs_rd & (bus.sel == fdc_pkg::SEL_DIGITAL_INPUT);
  wire fifo_sel = bus.dma_acknowledge | (bus.cs & (bus.sel == fdc_pkg::SEL_FIFO));

  // dor reset bit is active low; it dominates the self-clearing one
  wire dor_reset = ~dor_ff[fdc_pkg::DOR_RESET_N_BIT];
  wire soft_reset = dor_reset | sw_reset_ff;

  // disk change flag is the inverse of the cable line in every buffer setting
  wire disk_change_flag_flag = ~disk_change_flag_s;
  wire high_density_flag = ~((rate_ff == fdc_pkg::RATE_500K) | (rate_ff == fdc_pkg::RATE_1M));
  // strap 0: low at high rates, high at low rates; strap 1 inverts
  wire density_raw = high_density_flag ^ ident_ff;
  // internal buffers invert the cable level when the invert pin is high
  wire density_pin = invert_n_s ? ~density_raw : density_raw;

  wire [7:0] dir_ext = {disk_change_flag_flag, 4'hf, rate_ff, high_density_flag};
  wire [7:0] dir_alt = {~disk_change_flag_flag, 3'h0, dor_ff[fdc_pkg::DOR_DMA_GATE_BIT],
    precompensation_setting_dis_ff, rate_ff};
  wire [7:0] dir_basic = {disk_change_flag_flag, 7'h00};
  wire [7:0] dir_val = (i_mode == fdc_pkg::FDC_MODE_ALT) ? dir_alt :
    (i_mode == fdc_pkg::FDC_MODE_EXT) ? dir_ext : dir_basic;
  // basic mode leaves bits 6..0 undriven
  wire [7:0] dir_oe_n = (i_mode == fdc_pkg::FDC_MODE_BASIC) ? 8'h7f : 8'h00;

  // host configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rate_ff <= fdc_pkg::RATE_250K;
      precompensation_setting_ff <= fdc_pkg::PRECOMPENSATION_SETTING_RESET_VAL;
      precompensation_setting_dis_ff <= 1'b0;
      dor_ff <= fdc_pkg::DOR_RESET_VAL;
      sw_reset_ff <= 1'b0;
      power_down_ff <= 1'b0;
    end else begin
      if (wr_ccr) begin
        rate_ff <= bus.wdata[1:0];
        precompensation_setting_dis_ff <= bus.wdata[fdc_pkg::CCR_PRECOMPENSATION_SETTING_DIS_BIT];
      end else if (wr_rsr) begin
        rate_ff <= bus.wdata[1:0];
        precompensation_setting_ff <= bus.wdata[4:2];
      end
      if (wr_dor) begin
        dor_ff <= bus.wdata;
      end
      sw_reset_ff <= wr_rsr & bus.wdata[fdc_pkg::RSR_SW_RESET_BIT];
      if (wr_rsr & bus.wdata[fdc_pkg::RSR_POWER_DOWN_BIT]) begin
        power_down_ff <= 1'b1;
      end else if (soft_reset) begin
        power_down_ff <= 1'b0;
      end
    end
  end

  // strap is caught in the first cycle after release of the pin reset
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ident_take_ff <= 1'b1;
      ident_ff <= 1'b0;
      density_ff <= 1'b1;
    end else begin
      ident_take_ff <= 1'b0;
      if (ident_take_ff) begin
        ident_ff <= ident_s;
      end
      density_ff <= density_pin;
    end
  end

  // reset sequencing of the core; software resets drop the fifo only when unlocked
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      core_reset_ff <= 1'b1;
      fifo_reset_ff <= 1'b1;
      in_reset_ff <= 1'b1;
      polling_ff <= 1'b0;
    end else begin
      core_reset_ff <= soft_reset;
      fifo_reset_ff <= soft_reset & ~i_fifo_lock;
      in_reset_ff <= soft_reset;
      if (soft_reset) begin
        polling_ff <= 1'b0;
      end else if (in_reset_ff) begin
        polling_ff <= 1'b1;
      end
    end
  end

  // register reads, dma request and fifo strobes
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_ff <= 8'h00;
      oe_n_ff <= 8'hff;
      dma_req_ff <= 1'b0;
      fifo_wdata_ff <= 8'h00;
      fifo_write_ff <= 1'b0;
      fifo_read_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_dir ? dir_val : 8'h00;
      oe_n_ff <= rd_dir ? dir_oe_n : 8'hff;
      dma_req_ff <= bus.dma_enable & i_xfer_active & ~soft_reset;
      fifo_wdata_ff <= bus.wdata;
      fifo_write_ff <= fifo_sel & bus.wr & ~soft_reset;
      fifo_read_ff <= fifo_sel & bus.rd & ~soft_reset;
    end
  end

  // window rising samples clock, falling samples data; a byte closes on every eighth pair
  always_ff @(posedge i_mclk) begin
    if (i_reset | soft_reset) begin
      clk_sr_ff <= 8'h00;
      dat_sr_ff <= 8'h00;
      clk_byte_ff <= 8'h00;
      dat_byte_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      byte_valid_ff <= 1'b0;
      window_d_ff <= 1'b0;
    end else begin
      window_d_ff <= window_s;
      byte_valid_ff <= 1'b0;
      if (window_s & ~window_d_ff) begin
        clk_sr_ff <= {clk_sr_ff[6:0], rdata_s};
      end
      if (~window_s & window_d_ff) begin
        dat_sr_ff <= {dat_sr_ff[6:0], rdata_s};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == 3'h7) begin
          clk_byte_ff <= clk_sr_ff;
          dat_byte_ff <= {dat_sr_ff[6:0], rdata_s};
          byte_valid_ff <= 1'b1;
        end
      end
    end
  end

  assign bus.rdata = rdata_ff;
  assign bus.rdata_oe_n = oe_n_ff;
  assign bus.dma_request = dma_req_ff;
  assign o_density_select_out = density_ff;
  assign o_core_reset = core_reset_ff;
  assign o_fifo_reset = fifo_reset_ff;
  assign o_power_down = power_down_ff;
  assign o_polling = polling_ff;
  assign o_clock_byte = clk_byte_ff;
  assign o_data_byte = dat_byte_ff;
  assign o_byte_valid = byte_valid_ff;
  assign o_fifo_wdata = fifo_wdata_ff;
  assign o_fifo_write = fifo_write_ff;
  assign o_fifo_read = fifo_read_ff;
endmodule
`default_nettype wire

// ==== hdl/fdc_host.sv ====
// module: avalon-mm controlled host end driving register cycles and dma acknowledge
`timescale 1ns/1ps
`default_nettype none
module fdc_host (
  input wire logic i_mclk,
  input wire logic i_reset,
  fdc_if.host bus,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  fdc_pkg::fdc_state_t state_ff;
  logic [2:0] sel_ff;
  logic [7:0] wdata_ff, rdata_ff;
  logic wr_ff, dma_ff, dma_en_ff, cs_ff, rd_ff, bwr_ff, dma_acknowledge_ff;
  logic [31:0] avs_rdata_ff;
  logic wait_ff;

  wire hit_cmd = i_avs_write & (i_avs_address == fdc_pkg::AV_CMD);
  wire go = hit_cmd & i_avs_writedata[fdc_pkg::CMD_GO_BIT] & (state_ff == fdc_pkg::FDC_ST_IDLE);
  wire busy = state_ff != fdc_pkg::FDC_ST_IDLE;
  wire [31:0] rd_mux = (i_avs_address == fdc_pkg::AV_STATUS) ?
    {29'h0000_0000, dma_en_ff, bus.dma_request, busy} :
    (i_avs_address == fdc_pkg::AV_RDATA) ? {24'h00_0000, rdata_ff} :
    (i_avs_address == fdc_pkg::AV_WDATA) ? {24'h00_0000, wdata_ff} : fdc_pkg::AV_UNMAPPED;
  // data sits in a driven lane only when the device enables it
  wire [7:0] pin_rdata = bus.rdata & ~bus.rdata_oe_n;

  // slave answers one cycle after a request is seen
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wait_ff <= 1'b1;
      avs_rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(wait_ff & (i_avs_read | i_avs_write));
      avs_rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_ff <= fdc_pkg::FDC_ST_IDLE;
      sel_ff <= 3'h0;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      dma_ff <= 1'b0;
      dma_en_ff <= 1'b0;
      cs_ff <= 1'b0;
      rd_ff <= 1'b0;
      bwr_ff <= 1'b0;
      dma_acknowledge_ff <= 1'b0;
    end else begin
      // writes take effect at the edge that completes the avalon transfer
      if (i_avs_write & ~wait_ff & (i_avs_address == fdc_pkg::AV_WDATA)) begin
        wdata_ff <= i_avs_writedata[7:0];
      end
      case (state_ff)
        fdc_pkg::FDC_ST_IDLE: begin
          if (go & ~wait_ff) begin
            sel_ff <= i_avs_writedata[2:0];
            wr_ff <= i_avs_writedata[fdc_pkg::CMD_WR_BIT];
            dma_ff <= i_avs_writedata[fdc_pkg::CMD_DMA_BIT];
            dma_en_ff <= i_avs_writedata[fdc_pkg::CMD_DMA_BIT];
            state_ff <= fdc_pkg::FDC_ST_REQ;
          end
        end
        fdc_pkg::FDC_ST_REQ: begin
          // dma cycles use acknowledge alone with chip select idle
          cs_ff <= ~dma_ff;
          dma_acknowledge_ff <= dma_ff;
          rd_ff <= ~wr_ff;
          bwr_ff <= wr_ff;
          state_ff <= fdc_pkg::FDC_ST_DONE;
        end
        fdc_pkg::FDC_ST_DONE: begin
          cs_ff <= 1'b0;
          dma_acknowledge_ff <= 1'b0;
          rd_ff <= 1'b0;
          bwr_ff <= 1'b0;
          if (~rd_ff & ~bwr_ff) begin
            state_ff <= fdc_pkg::FDC_ST_IDLE;
          end
        end
        default: state_ff <= fdc_pkg::FDC_ST_IDLE;
      endcase
      // device read data stands the cycle after the strobe, when the strobes are low again
      if ((state_ff == fdc_pkg::FDC_ST_DONE) & ~rd_ff & ~bwr_ff & ~wr_ff) begin
        rdata_ff <= pin_rdata;
      end
    end
  end

  assign o_avs_readdata = avs_rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign bus.cs = cs_ff;
  assign bus.rd = rd_ff;
  assign bus.wr = bwr_ff;
  assign bus.sel = sel_ff;
  assign bus.wdata = wdata_ff;
  assign bus.dma_acknowledge = dma_acknowledge_ff;
  assign bus.dma_enable = dma_en_ff;
endmodule
`default_nettype wire

// ==== hdl/fdc_if.sv ====
// interface: host bus and dma handshake between both ends
`timescale 1ns/1ps
`default_nettype none
interface fdc_if;
  logic cs;
  logic rd;
  logic wr;
  logic [2:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rdata_oe_n;
  logic dma_request;
  logic dma_acknowledge;
  logic dma_enable;

  modport device (
    input cs, rd, wr, sel, wdata, dma_acknowledge, dma_enable,
    output rdata, rdata_oe_n, dma_request
  );
  modport host (
    output cs, rd, wr, sel, wdata, dma_acknowledge, dma_enable,
    input rdata, rdata_oe_n, dma_request
  );
endinterface
`default_nettype wire

// ==== hdl/fdc_pkg.sv ====
// package: constants and types shared by the floppy input/config/reset block
package fdc_pkg;
  // compatibility modes
  typedef enum logic [1:0] {
    FDC_MODE_BASIC = 2'h0,
    FDC_MODE_EXT = 2'h1,
    FDC_MODE_ALT = 2'h2
  } fdc_mode_t;

  // rate select codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;

  // device-side register selects on the link
  localparam logic [2:0] SEL_DIGITAL_INPUT = 3'h0;
  localparam logic [2:0] SEL_CONFIG_CONTROL = 3'h1;
  localparam logic [2:0] SEL_DIGITAL_OUTPUT = 3'h2;
  localparam logic [2:0] SEL_RATE_SELECT = 3'h3;
  localparam logic [2:0] SEL_FIFO = 3'h4;

  // digital output register fields
  localparam int DOR_RESET_N_BIT = 2;
  localparam int DOR_DMA_GATE_BIT = 3;
  // rate select register fields
  localparam int RSR_SW_RESET_BIT = 7;
  localparam int RSR_POWER_DOWN_BIT = 6;
  // config control register field and register reset values
  localparam int CCR_PRECOMPENSATION_SETTING_DIS_BIT = 2;
  localparam logic [7:0] DOR_RESET_VAL = 8'h00;
  localparam logic [2:0] PRECOMPENSATION_SETTING_RESET_VAL = 3'h0;

  // controller avalon map (word offsets as byte addresses)
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_WDATA = 4'h4;
  localparam logic [3:0] AV_STATUS = 4'h8;
  localparam logic [3:0] AV_RDATA = 4'hc;
  localparam logic [31:0] AV_UNMAPPED = 32'h0000_0000;
  // cmd word fields
  localparam int CMD_GO_BIT = 8;
  localparam int CMD_WR_BIT = 9;
  localparam int CMD_DMA_BIT = 10;

  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    FDC_ST_IDLE = 2'b00,
    FDC_ST_REQ = 2'b01,
    FDC_ST_DONE = 2'b11
  } fdc_state_t;
endpackage

// ==== hdl/fdc_sync.sv ====
// module: three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module fdc_sync (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);
  logic [fdc_pkg::SYNC_STAGES-1:0] stage_ff;
  logic level_ff;
  // the stages keep shifting through reset so a strap has settled when reset is released
  always_ff @(posedge i_mclk) begin
    stage_ff <= {stage_ff[fdc_pkg::SYNC_STAGES-2:0], i_pin};
    if (i_reset) begin
      level_ff <= stage_ff[fdc_pkg::SYNC_STAGES-1];
    end else if (stage_ff[fdc_pkg::SYNC_STAGES-2] == stage_ff[fdc_pkg::SYNC_STAGES-1]) begin
      level_ff <= stage_ff[fdc_pkg::SYNC_STAGES-1];
    end
  end
  assign o_level = level_ff;
endmodule
`default_nettype wire

// ==== tb/fdc_props.sv ====
// checker: link protocol and input register layout properties of the floppy block
`timescale 1ns/1ps
`default_nettype none
module fdc_props (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire fdc_pkg::fdc_mode_t i_mode,
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic [2:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [7:0] rdata_oe_n,
  input wire logic dma_request,
  input wire logic dma_acknowledge,
  input wire logic dma_enable
);
  logic [1:0] rate_ff;
  logic gate_ff;
  logic stub_ff;
  wire rd_dir = cs && rd && (sel == fdc_pkg::SEL_DIGITAL_INPUT);
  wire rd_wo = cs && rd && (sel == fdc_pkg::SEL_CONFIG_CONTROL || sel == fdc_pkg::SEL_RATE_SELECT);
  wire wr_cfg = cs && wr && (sel == fdc_pkg::SEL_CONFIG_CONTROL);
  wire wr_rsr = cs && wr && (sel == fdc_pkg::SEL_RATE_SELECT);
  wire wr_dor = cs && wr && (sel == fdc_pkg::SEL_DIGITAL_OUTPUT);
  wire hd = (rate_ff == fdc_pkg::RATE_300K) || (rate_ff == fdc_pkg::RATE_250K);
  wire is_ext = (i_mode == fdc_pkg::FDC_MODE_EXT);
  wire is_alt = (i_mode == fdc_pkg::FDC_MODE_ALT);
  // shadow of host writes; only the pin reset clears it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rate_ff <= fdc_pkg::RATE_250K;
      gate_ff <= 1'b0;
      stub_ff <= 1'b0;
    end else begin
      if (wr_cfg || wr_rsr) rate_ff <= wdata[1:0];
      if (wr_dor) gate_ff <= wdata[fdc_pkg::DOR_DMA_GATE_BIT];
      if (wr_cfg) stub_ff <= wdata[fdc_pkg::CCR_PRECOMPENSATION_SETTING_DIS_BIT];
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_basic_tristate: assert property (rd_dir && i_mode == fdc_pkg::FDC_MODE_BASIC |=> rdata_oe_n == 8'h7f)
    else $error("basic input read drives wrong bits");
  a_ext_layout: assert property (rd_dir && is_ext |=> rdata_oe_n == 8'h00 && rdata[6:1] == {4'hf, rate_ff})
    else $error("extended input read layout wrong");
  a_ext_density: assert property (rd_dir && is_ext |=> rdata[0] == hd)
    else $error("high density flag wrong");
  a_alt_layout: assert property (rd_dir && is_alt |=> rdata[6:4] == 3'h0 && rdata[1:0] == rate_ff)
    else $error("alternate input read layout wrong");
  a_alt_mirror: assert property (rd_dir && is_alt |=> rdata[3:2] == {gate_ff, stub_ff})
    else $error("alternate mirror bits wrong");
  a_wo_float: assert property (rd_wo |=> rdata_oe_n == 8'hff)
    else $error("write-only register drove data");
  a_reset_idle: assert property ($fell(i_reset) |-> rdata_oe_n == 8'hff && !dma_request)
    else $error("link not idle after reset");
  a_dma_gated: assert property (!dma_enable |=> !dma_request)
    else $error("dma request without enable");
  a_dma_acknowledge_alone: assert property (dma_acknowledge |-> !cs)
    else $error("chip select active with dma acknowledge");
  c_alt_read: cover property (rd_dir && is_alt);
  c_dma_req: cover property (dma_request);
  c_dma_acknowledge_read: cover property (dma_acknowledge && rd);
endmodule
`default_nettype wire

// ==== tb/test_fdc_input_config_reset.sv ====
// testbench: both ends joined, driven over avalon and the drive pins
`timescale 1ns/1ps
`default_nettype none
module test_fdc_input_config_reset;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  fdc_pkg::fdc_mode_t i_mode = fdc_pkg::FDC_MODE_BASIC;
  logic chg_n = 1'b1, strap = 1'b0, inv_n = 1'b0, lock = 1'b0, xfer = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_wdata = 32'h0000_0000;
  logic [31:0] avs_rdata;
  logic avs_wait, density, core_rst, fifo_rst, pwr_dn, polling, fifo_rd;
  logic rdd = 1'b0, win = 1'b0, byte_valid, fifo_wr;
  logic [7:0] clk_byte, dat_byte, fifo_wd, got_clk = 8'h00, got_dat = 8'h00, got_fw = 8'h00;
  int n_fail = 0, samples_checked = 0, seed = 63801, cyc = 0, n_rd = 0, n_byte = 0;
  fdc_if bus_if();
  always #2.5 i_mclk = ~i_mclk;
  fdc_device u_fdc_device (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus_if.device), .i_mode(i_mode),
    .i_disk_change_n(chg_n), .i_ident_strap(strap), .i_invert_n(inv_n), .i_fifo_lock(lock),
    .i_read_data(rdd), .i_data_window(win), .i_xfer_active(xfer), .o_density_select_out(density),
    .o_core_reset(core_rst), .o_fifo_reset(fifo_rst), .o_power_down(pwr_dn), .o_polling(polling),
    .o_clock_byte(clk_byte), .o_data_byte(dat_byte), .o_byte_valid(byte_valid), .o_fifo_wdata(fifo_wd),
    .o_fifo_write(fifo_wr), .o_fifo_read(fifo_rd));
  fdc_host u_fdc_host (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus_if.host), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait));
  fdc_props u_fdc_props (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode(i_mode), .cs(bus_if.cs), .rd(bus_if.rd),
    .wr(bus_if.wr), .sel(bus_if.sel), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rdata_oe_n(bus_if.rdata_oe_n),
    .dma_request(bus_if.dma_request), .dma_acknowledge(bus_if.dma_acknowledge), .dma_enable(bus_if.dma_enable));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (fifo_rd === 1'b1) n_rd = n_rd + 1;
    if (fifo_wr === 1'b1) got_fw = fifo_wd;
    if (byte_valid === 1'b1) begin
      n_byte = n_byte + 1;
      got_clk = clk_byte;
      got_dat = dat_byte;
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h0, exp}, {7'h0, got});
  endtask
  function automatic logic hd(input logic [1:0] r);
    hd = (r == fdc_pkg::RATE_300K) || (r == fdc_pkg::RATE_250K);
  endfunction
  function automatic logic [7:0] exp_dir(input fdc_pkg::fdc_mode_t m, input logic c, input logic [1:0] r,
    input logic g, input logic s);
    case (m)
      fdc_pkg::FDC_MODE_BASIC: exp_dir = {~c, 7'h00};
      fdc_pkg::FDC_MODE_EXT: exp_dir = {~c, 4'hf, r, hd(r)};
      default: exp_dir = {c, 3'h0, g, s, r};
    endcase
  endfunction
  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_wdata <= d;
    do begin
      @(posedge i_mclk);
    end while (avs_wait !== 1'b0);
    q = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge i_mclk);
  endtask
  // k[0] write, k[1] dma; waits until the host end is idle, then fetches read data
  task automatic dev(input logic [1:0] k, input logic [2:0] s, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    if (k[0]) av(1'b1, fdc_pkg::AV_WDATA, {24'h0, d}, r);
    av(1'b1, fdc_pkg::AV_CMD, {21'h0, k[1], k[0], 1'b1, 5'h0, s}, r);
    do begin
      av(1'b0, fdc_pkg::AV_STATUS, 32'h0, r);
    end while (r[0] !== 1'b0);
    av(1'b0, fdc_pkg::AV_RDATA, 32'h0, r);
    q = r[7:0];
  endtask
  task automatic do_reset(input fdc_pkg::fdc_mode_t m, input logic s);
    i_reset <= 1'b1;
    i_mode <= m;
    strap <= s;
    repeat (4) @(posedge i_mclk);
    chk1("density in reset", 1'b1, density);
    i_reset <= 1'b0;
    // the captured strap reaches the density output one edge after it is taken
    repeat (3) @(posedge i_mclk);
  endtask
  initial begin
    logic [31:0] r;
    logic [7:0] q;
    logic [7:0] cb, db;
    logic [1:0] rt;
    logic g, st;
    fdc_pkg::fdc_mode_t m;
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      m = fdc_pkg::fdc_mode_t'(2'(i % 3));
      rt = (i < 4) ? 2'(i) : r[1:0];
      g = r[3];
      st = (m == fdc_pkg::FDC_MODE_ALT) && r[2];
      chg_n <= r[8];
      inv_n <= r[9];
      lock <= r[4];
      do_reset(m, r[5]);
      chk1("core reset", 1'b1, core_rst);
      chk1("density", hd(fdc_pkg::RATE_250K) ^ r[5] ^ r[9], density);
      dev(2'd1, fdc_pkg::SEL_DIGITAL_OUTPUT, {4'h0, g, 3'h4}, q);
      chk1("core reset", 1'b0, core_rst);
      chk1("polling", 1'b1, polling);
      dev(2'd1, fdc_pkg::SEL_CONFIG_CONTROL, {5'h0, st, rt}, q);
      dev(2'd0, fdc_pkg::SEL_DIGITAL_INPUT, 8'h00, q);
      chk8("input reg", exp_dir(m, r[8], rt, g, st), q);
      dev(2'd0, fdc_pkg::SEL_CONFIG_CONTROL, 8'h00, q);
      chk8("write-only read", 8'h00, q);
      chk1("density", hd(rt) ^ r[5] ^ r[9], density);
      dev(2'd1, fdc_pkg::SEL_RATE_SELECT, {2'b01, 4'h0, rt}, q);
      chk1("power down", 1'b1, pwr_dn);
      dev(2'd1, fdc_pkg::SEL_RATE_SELECT, {2'b10, 4'h0, rt}, q);
      chk1("power down", 1'b0, pwr_dn);
      dev(2'd0, fdc_pkg::SEL_DIGITAL_INPUT, 8'h00, q);
      chk8("input reg", exp_dir(m, r[8], rt, g, st), q);
      chk1("core reset", 1'b0, core_rst);
      dev(2'd1, fdc_pkg::SEL_DIGITAL_OUTPUT, {4'h0, g, 3'h0}, q);
      dev(2'd1, fdc_pkg::SEL_RATE_SELECT, {2'b10, 4'h0, rt}, q);
      chk1("core reset", 1'b1, core_rst);
      chk1("fifo reset", ~r[4], fifo_rst);
      chk1("density", hd(rt) ^ r[5] ^ r[9], density);
      $display("test %0d done", i);
    end
    do_reset(fdc_pkg::FDC_MODE_EXT, 1'b0);
    dev(2'd1, fdc_pkg::SEL_DIGITAL_OUTPUT, 8'h0c, q);
    xfer <= 1'b1;
    dev(2'd2, fdc_pkg::SEL_FIFO, 8'h00, q);
    chk1("dma request", 1'b1, bus_if.dma_request);
    chk8("fifo reads", 8'h01, n_rd[7:0]);
    av(1'b0, fdc_pkg::AV_STATUS, 32'h0, r);
    chk8("status", 8'h06, r[7:0]);
    xfer <= 1'b0;
    // serial byte: clock bit on the rising window, data bit on the falling window
    r = $random(seed);
    cb = r[7:0];
    db = r[15:8];
    for (int b = 7; b >= 0; b--) begin
      rdd <= cb[b];
      repeat (5) @(posedge i_mclk);
      win <= 1'b1;
      repeat (5) @(posedge i_mclk);
      rdd <= db[b];
      repeat (5) @(posedge i_mclk);
      win <= 1'b0;
      repeat (5) @(posedge i_mclk);
    end
    repeat (6) @(posedge i_mclk);
    chk8("byte count", 8'h01, n_byte[7:0]);
    chk8("clock byte", cb, got_clk);
    chk8("data byte", db, got_dat);
    dev(2'd3, fdc_pkg::SEL_FIFO, db, q);
    chk8("fifo write data", db, got_fw);
    av(1'b0, 4'h2, 32'h0, r);
    chk1("unmapped read", 1'b0, |r);
    $display("dma and serial tests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
